//--- shared/mif_cfg.svh
`ifndef MIF_CFG_SVH
`define MIF_CFG_SVH
// --------------------------------
// bus geometry
// --------------------------------
`define MIF_AW 6
`define MIF_DW 32
`define MIF_SW 4
`define MIF_LANE 2
`define MIF_IXW 4
`define MIF_RW 8
`define MIF_RESP_OK 2'h0
`define MIF_RESP_ERR 2'h2
// --------------------------------
// register indices, byte offset = 4 * index
// --------------------------------
`define MIF_IX_EDGE 4'h0
`define MIF_IX_CTRL0 4'h1
`define MIF_IX_CTRL1 4'h2
`define MIF_IX_CTRL2 4'h3
`define MIF_IX_MFG0 4'h4
`define MIF_IX_EVT 4'h7
`define MIF_IX_MASK 4'h8
`define MIF_NREG 9
// --------------------------------
// sources and field positions
// --------------------------------
`define MIF_SRC_N 11
`define MIF_GRP_N 3
`define MIF_PIN_N 2
`define MIF_SEL_W 2
`define MIF_VEC_W 4
`define MIF_NIB 4
`define MIF_S_PIN0 4'h0
`define MIF_S_PIN1 4'h8
`define MIF_C0_HI 2
`define MIF_C1_LO 3
`define MIF_C1_HI 6
`define MIF_C2_LO 7
`define MIF_C2_HI 10
`define MIF_GATE 0
`define MIF_EN_LO 0
`define MIF_EN_HI 3
`define MIF_FL_LO 4
`define MIF_FL_HI 7
`define MIF_C0_EN_LO 1
`define MIF_C0_FL_HI 6
`define MIF_EDGE_HI 3
`define MIF_SRC_FULL 11'h7FF
`define MIF_SRC_SMALL 11'h1FD
`define MIF_MFG_FULL 8'hFF
`define MIF_MFG_HALF 8'h33
`define MIF_EDGE_RISE 2'h1
`define MIF_EDGE_FALL 2'h2
`define MIF_EDGE_BOTH 2'h3
`define MIF_EVT_N 2
`define MIF_EVT_ACK 0
`define MIF_EVT_STALL 1
`endif

//--- shared/mif_pkg.sv
`include "mif_cfg.svh"
package mif_pkg;
  // --------------------------------
  // carriers
  // --------------------------------
  typedef struct packed {
    logic serial_port;
    logic twowire;
    logic time_base1;
    logic time_base0;
    logic converter;
    logic comparator;
    logic t2_compare;
    logic t2_period;
    logic t1_compare;
    logic t1_period;
    logic t0_compare;
    logic t0_period;
    logic eeprom;
    logic low_voltage;
  } mif_src_s;
  typedef struct packed {
    logic en;
    logic [`MIF_AW-1:0] addr;
    logic [`MIF_RW-1:0] data;
  } mif_wr_s;
  typedef enum logic {
    MIF_W_IDLE,
    MIF_W_RESP
  } mif_wst_e;
endpackage : mif_pkg

//--- hw/mif_pin_edge.sv
`timescale 1ns/100ps
`include "mif_cfg.svh"
module mif_pin_edge
  import mif_pkg::*;
(
  input logic clk_i,
  input logic rst_b_i,
  input logic pin_i,
  input logic [`MIF_SEL_W-1:0] sel_i,
  output logic edge_o
);
  logic s1, s2, s3, lvl, next_lvl, hit, next_hit;
  // --------------------------------
  // three-stage sampler, level moves once stages 2 and 3 agree
  // --------------------------------
  always_comb begin
    next_lvl = (s2 == s3) ? s3 : lvl;
    next_hit = 1'b0;
    if (next_lvl && !lvl) begin
      next_hit = (sel_i == `MIF_EDGE_RISE) || (sel_i == `MIF_EDGE_BOTH); // [R1]
    end
    if (!next_lvl && lvl) begin
      next_hit = (sel_i == `MIF_EDGE_FALL) || (sel_i == `MIF_EDGE_BOTH); // [R1]
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      lvl <= 1'b0;
      hit <= 1'b0;
    end else begin
      s1 <= pin_i;
      s2 <= s1;
      s3 <= s2;
      lvl <= next_lvl;
      hit <= next_hit;
    end
  end
  assign edge_o = hit;
endmodule : mif_pin_edge

//--- hw/mif_axil_slave.sv
`timescale 1ns/100ps
`include "mif_cfg.svh"
module mif_axil_slave
  import mif_pkg::*;
(
  input logic clk_i,
  input logic rst_b_i,
  input logic [`MIF_AW-1:0] awaddr_i,
  input logic awvalid_i,
  output logic awready_o,
  input logic [`MIF_DW-1:0] wdata_i,
  input logic [`MIF_SW-1:0] wstrb_i,
  input logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input logic bready_i,
  input logic [`MIF_AW-1:0] araddr_i,
  input logic arvalid_i,
  output logic arready_o,
  output logic [`MIF_DW-1:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input logic rready_i,
  output mif_wr_s wr_o,
  input logic wr_hit_i,
  output logic [`MIF_AW-1:0] rd_addr_o,
  input logic [`MIF_RW-1:0] rd_data_i,
  input logic rd_hit_i
);
  mif_wst_e st, next_st;
  logic aw_got, next_aw_got, w_got, next_w_got, lane0, next_lane0;
  logic [`MIF_AW-1:0] waddr, next_waddr;
  logic [`MIF_RW-1:0] wdat, next_wdat;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic rvalid, next_rvalid;
  logic [`MIF_DW-1:0] rdata, next_rdata;
  logic go;
  // --------------------------------
  // write path: address and data in either order
  // --------------------------------
  assign awready_o = (st == MIF_W_IDLE) && !aw_got;
  assign wready_o = (st == MIF_W_IDLE) && !w_got;
  assign go = (st == MIF_W_IDLE) && aw_got && w_got;
  assign wr_o = '{en: go && lane0, addr: waddr, data: wdat};
  always_comb begin
    next_st = st;
    next_aw_got = aw_got;
    next_w_got = w_got;
    next_waddr = waddr;
    next_wdat = wdat;
    next_lane0 = lane0;
    next_bresp = bresp;
    if (awvalid_i && awready_o) begin
      next_aw_got = 1'b1;
      next_waddr = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      next_w_got = 1'b1;
      next_wdat = wdata_i[`MIF_RW-1:0];
      next_lane0 = wstrb_i[0];
    end
    case (st)
      MIF_W_IDLE: begin
        if (go) begin
          next_st = MIF_W_RESP;
          next_aw_got = 1'b0;
          next_w_got = 1'b0;
          next_bresp = wr_hit_i ? `MIF_RESP_OK : `MIF_RESP_ERR;
        end
      end
      MIF_W_RESP: begin
        if (bready_i) begin
          next_st = MIF_W_IDLE;
        end
      end
      default: next_st = MIF_W_IDLE;
    endcase
  end
  // --------------------------------
  // read path: data registered one cycle after the address
  // --------------------------------
  assign arready_o = !rvalid;
  assign rd_addr_o = araddr_i;
  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && rready_i) begin
      next_rvalid = 1'b0;
    end
    if (arvalid_i && arready_o) begin
      next_rvalid = 1'b1;
      next_rdata = {{(`MIF_DW-`MIF_RW){1'b0}}, rd_data_i};
      next_rresp = rd_hit_i ? `MIF_RESP_OK : `MIF_RESP_ERR;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      st <= MIF_W_IDLE;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      waddr <= '0;
      wdat <= '0;
      lane0 <= 1'b0;
      bresp <= `MIF_RESP_OK;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= `MIF_RESP_OK;
    end else begin
      st <= next_st;
      aw_got <= next_aw_got;
      w_got <= next_w_got;
      waddr <= next_waddr;
      wdat <= next_wdat;
      lane0 <= next_lane0;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end
  assign bvalid_o = (st == MIF_W_RESP);
  assign bresp_o = bresp;
  assign rvalid_o = rvalid;
  assign rdata_o = rdata;
  assign rresp_o = rresp;
endmodule : mif_axil_slave

//--- hw/mif_irq_bank.sv
// Register access over AXI4-Lite and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`include "mif_cfg.svh"
// --------------------------------
// Functional notes
// R1 - edge code: off, rise, fall, both
// R2 - pin1 select bits 3:2, pin0 1:0
// R3 - control 0 bit 0 gates all vectors
// R4 - control 0: flags 6..4, enables 3..1
// R5 - control 1: tb0, converter, mf2, mf1 pairs
// R6 - control 2: serial, twowire, pin1, tb1 pairs
// R7 - group flag/enable pairs feed multi-function flags
// R8 - unimplemented bits ignore writes, read zero
// R9 - every source: writable enable, pending flag
// R10 - small variant drops comparator, twowire, serial
// R11 - flags set regardless; vector needs enable, gate
// R12 - taking a vector clears the gate
// R13 - taking a pin vector clears its flag
// R14 - full stack keeps requests pending
// R15 - all bits clear at reset
// R16 - fixed priority picks vector, pin0 highest
// --------------------------------
module mif_irq_bank
  import mif_pkg::*;
#(
  parameter bit SMALL_VARIANT = 1'b0
) (
  input logic clk_i,
  input logic rst_b_i,
  input logic [`MIF_AW-1:0] awaddr_i,
  input logic awvalid_i,
  output logic awready_o,
  input logic [`MIF_DW-1:0] wdata_i,
  input logic [`MIF_SW-1:0] wstrb_i,
  input logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input logic bready_i,
  input logic [`MIF_AW-1:0] araddr_i,
  input logic arvalid_i,
  output logic arready_o,
  output logic [`MIF_DW-1:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input logic rready_i,
  input logic [`MIF_PIN_N-1:0] ext_pin_i,
  input mif_src_s src_i,
  input logic stack_full_i,
  input logic irq_ack_i,
  output logic irq_req_o,
  output logic [`MIF_VEC_W-1:0] vec_sel_o,
  output logic global_irq_gate_o,
  output logic irq_o
);
  // --------------------------------
  // state
  // --------------------------------
  localparam logic [`MIF_SRC_N-1:0] SRC_MASK =
    SMALL_VARIANT ? `MIF_SRC_SMALL : `MIF_SRC_FULL;
  logic [`MIF_SRC_N-1:0] flag;
  logic [`MIF_SRC_N-1:0] next_flag;
  logic [`MIF_SRC_N-1:0] enab;
  logic [`MIF_SRC_N-1:0] next_enab;
  logic [`MIF_SRC_N-1:0] set_src;
  logic [`MIF_SRC_N-1:0] pend;
  logic gate;
  logic next_gate;
  logic [`MIF_PIN_N*`MIF_SEL_W-1:0] edge_sel;
  logic [`MIF_PIN_N*`MIF_SEL_W-1:0] next_edge_sel;
  logic [`MIF_PIN_N-1:0] pin_edge;
  logic [`MIF_GRP_N-1:0] grp_req;
  logic [`MIF_RW-1:0] mfg [`MIF_GRP_N];
  logic [`MIF_NIB-1:0] mf_set [`MIF_GRP_N];
  logic req;
  logic next_req;
  logic [`MIF_VEC_W-1:0] vec;
  logic [`MIF_VEC_W-1:0] next_vec;
  logic take;
  logic [`MIF_EVT_N-1:0] evt;
  logic [`MIF_EVT_N-1:0] next_evt;
  logic [`MIF_EVT_N-1:0] evt_set;
  logic [`MIF_EVT_N-1:0] evt_mask;
  logic [`MIF_EVT_N-1:0] next_evt_mask;
  logic irq;
  logic next_irq;
  // --------------------------------
  // register access
  // --------------------------------
  mif_wr_s wr;
  logic wr_hit;
  logic rd_hit;
  logic [`MIF_AW-1:0] rd_addr;
  logic [`MIF_RW-1:0] rd_data;
  logic [`MIF_IXW-1:0] wr_word;
  logic [`MIF_IXW-1:0] rd_word;
  logic [`MIF_NREG-1:0] wsel;
  logic [`MIF_RW-1:0] rd_regs [`MIF_NREG];

  mif_axil_slave u_bus (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .bresp_o(bresp_o),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .araddr_i(araddr_i),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .rdata_o(rdata_o),
    .rresp_o(rresp_o),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .wr_o(wr),
    .wr_hit_i(wr_hit),
    .rd_addr_o(rd_addr),
    .rd_data_i(rd_data),
    .rd_hit_i(rd_hit)
  );

  assign wr_word = wr.addr[`MIF_AW-1:`MIF_LANE];
  assign rd_word = rd_addr[`MIF_AW-1:`MIF_LANE];
  assign wr_hit = wr_word < `MIF_IXW'(`MIF_NREG);
  assign rd_hit = rd_word < `MIF_IXW'(`MIF_NREG);
  // unmapped reads return zero with an error response
  assign rd_data = rd_hit ? rd_regs[rd_word] : '0;

  for (genvar r = 0; r < `MIF_NREG; r++) begin : g_sel
    assign wsel[r] = wr.en && (wr_word == `MIF_IXW'(r));
  end

  // --------------------------------
  // external pins
  // --------------------------------
  for (genvar p = 0; p < `MIF_PIN_N; p++) begin : g_pin
    mif_pin_edge u_edge (
      .clk_i(clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(ext_pin_i[p]),
      .sel_i(edge_sel[p*`MIF_SEL_W +: `MIF_SEL_W]), // [R2]
      .edge_o(pin_edge[p])
    );
  end

  // --------------------------------
  // multi-function groups
  // --------------------------------
  assign mf_set[0] = {2'h0, src_i.t0_compare, src_i.t0_period};
  assign mf_set[1] = {src_i.t2_compare, src_i.t2_period, src_i.t1_compare, src_i.t1_period};
  assign mf_set[2] = {2'h0, src_i.eeprom, src_i.low_voltage};

  for (genvar g = 0; g < `MIF_GRP_N; g++) begin : g_grp
    // the second group carries timer 2 only on the full variant
    localparam logic [`MIF_RW-1:0] GMASK =
      (g == 1 && !SMALL_VARIANT) ? `MIF_MFG_FULL : `MIF_MFG_HALF;
    logic [`MIF_RW-1:0] grp;
    logic [`MIF_RW-1:0] next_grp;
    always_comb begin
      next_grp = grp;
      if (wsel[`MIF_IX_MFG0 + g]) begin
        next_grp = wr.data;
      end
      next_grp[`MIF_FL_HI:`MIF_FL_LO] = next_grp[`MIF_FL_HI:`MIF_FL_LO] | mf_set[g]; // [R7] [R11]
      next_grp = next_grp & GMASK; // [R8]
    end
    always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
        grp <= '0; // [R15]
      end else begin
        grp <= next_grp;
      end
    end
    assign mfg[g] = grp;
    assign grp_req[g] = |(grp[`MIF_FL_HI:`MIF_FL_LO] & grp[`MIF_EN_HI:`MIF_EN_LO]); // [R7]
    assign rd_regs[`MIF_IX_MFG0 + g] = mfg[g];
  end

  // --------------------------------
  // primary flags, enables, gate, vector choice
  // --------------------------------
  assign set_src = {src_i.serial_port, src_i.twowire, pin_edge[1], src_i.time_base1,
                    src_i.time_base0, src_i.converter, grp_req[2], grp_req[1],
                    grp_req[0], src_i.comparator, pin_edge[0]};
  // a taken vector is the one presented in the same cycle as the acknowledge
  assign take = req && irq_ack_i;

  always_comb begin
    next_flag = flag;
    next_enab = enab;
    next_gate = gate;
    next_edge_sel = edge_sel;
    if (wsel[`MIF_IX_EDGE]) begin
      next_edge_sel = wr.data[`MIF_EDGE_HI:0]; // [R2] [R8]
    end
    if (wsel[`MIF_IX_CTRL0]) begin
      next_gate = wr.data[`MIF_GATE]; // [R3]
      next_enab[`MIF_C0_HI:0] = wr.data[`MIF_EN_HI:`MIF_C0_EN_LO]; // [R4] [R9]
      next_flag[`MIF_C0_HI:0] = wr.data[`MIF_C0_FL_HI:`MIF_FL_LO]; // [R4] [R9]
    end
    if (wsel[`MIF_IX_CTRL1]) begin
      next_enab[`MIF_C1_HI:`MIF_C1_LO] = wr.data[`MIF_EN_HI:`MIF_EN_LO]; // [R5]
      next_flag[`MIF_C1_HI:`MIF_C1_LO] = wr.data[`MIF_FL_HI:`MIF_FL_LO]; // [R5]
    end
    if (wsel[`MIF_IX_CTRL2]) begin
      next_enab[`MIF_C2_HI:`MIF_C2_LO] = wr.data[`MIF_EN_HI:`MIF_EN_LO]; // [R6]
      next_flag[`MIF_C2_HI:`MIF_C2_LO] = wr.data[`MIF_FL_HI:`MIF_FL_LO]; // [R6]
    end
    if (take) begin
      // clearing wins over a gate write so nesting needs a later write
      next_gate = 1'b0; // [R12]
      if (vec == `MIF_S_PIN0) begin
        next_flag[`MIF_S_PIN0] = 1'b0; // [R13]
      end
      if (vec == `MIF_S_PIN1) begin
        next_flag[`MIF_S_PIN1] = 1'b0; // [R13]
      end
    end
    next_flag = next_flag | set_src; // [R11]
    next_flag = next_flag & SRC_MASK; // [R10]
    next_enab = next_enab & SRC_MASK; // [R10]
    pend = next_flag & next_enab;
    next_vec = vec;
    for (int i = `MIF_SRC_N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        next_vec = `MIF_VEC_W'(i); // [R16]
      end
    end
    next_req = next_gate && (|pend) && !stack_full_i; // [R3] [R11] [R14]
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      flag <= '0; // [R15]
      enab <= '0;
      gate <= 1'b0;
      edge_sel <= '0;
      req <= 1'b0;
      vec <= '0;
    end else begin
      flag <= next_flag;
      enab <= next_enab;
      gate <= next_gate;
      edge_sel <= next_edge_sel;
      req <= next_req;
      vec <= next_vec;
    end
  end

  // --------------------------------
  // event status and interrupt line
  // --------------------------------
  always_comb begin
    evt_set = '0;
    evt_set[`MIF_EVT_ACK] = take;
    evt_set[`MIF_EVT_STALL] = gate && (|(flag & enab)) && stack_full_i; // [R14]
    next_evt = evt;
    next_evt_mask = evt_mask;
    if (wsel[`MIF_IX_EVT]) begin
      next_evt = evt & ~wr.data[`MIF_EVT_N-1:0];
    end
    // a new event in the clearing cycle is kept
    next_evt = next_evt | evt_set;
    if (wsel[`MIF_IX_MASK]) begin
      next_evt_mask = wr.data[`MIF_EVT_N-1:0];
    end
    next_irq = |(next_evt & next_evt_mask);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      evt <= '0;
      evt_mask <= '0;
      irq <= 1'b0;
    end else begin
      evt <= next_evt;
      evt_mask <= next_evt_mask;
      irq <= next_irq;
    end
  end

  // --------------------------------
  // read map, empty positions read zero
  // --------------------------------
  assign rd_regs[`MIF_IX_EDGE] = {{(`MIF_RW-`MIF_PIN_N*`MIF_SEL_W){1'b0}}, edge_sel}; // [R8]
  assign rd_regs[`MIF_IX_CTRL0] = {1'b0, flag[`MIF_C0_HI:0], enab[`MIF_C0_HI:0], gate}; // [R4]
  assign rd_regs[`MIF_IX_CTRL1] = {flag[`MIF_C1_HI:`MIF_C1_LO], enab[`MIF_C1_HI:`MIF_C1_LO]}; // [R5]
  assign rd_regs[`MIF_IX_CTRL2] = {flag[`MIF_C2_HI:`MIF_C2_LO], enab[`MIF_C2_HI:`MIF_C2_LO]}; // [R6]
  assign rd_regs[`MIF_IX_EVT] = {{(`MIF_RW-`MIF_EVT_N){1'b0}}, evt};
  assign rd_regs[`MIF_IX_MASK] = {{(`MIF_RW-`MIF_EVT_N){1'b0}}, evt_mask};

  // --------------------------------
  // core side
  // --------------------------------
  assign irq_req_o = req;
  assign vec_sel_o = vec;
  assign global_irq_gate_o = gate;
  assign irq_o = irq;
endmodule : mif_irq_bank

//--- test/mif_irq_properties.sv
`timescale 1ns/100ps
`include "mif_cfg.svh"
module mif_irq_props
  import mif_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic awvalid_i,
  input wire logic awready_o,
  input wire logic wvalid_i,
  input wire logic wready_o,
  input wire logic [1:0] bresp_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic arvalid_i,
  input wire logic arready_o,
  input wire logic [`MIF_DW-1:0] rdata_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic stack_full_i,
  input wire logic irq_ack_i,
  input wire logic irq_req_o,
  input wire logic [`MIF_VEC_W-1:0] vec_sel_o,
  input wire logic global_irq_gate_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // ------------------------------
  // sequences
  // ------------------------------
  sequence s_wr_taken;
    awvalid_i && awready_o && wvalid_i && wready_o;
  endsequence
  sequence s_wr_answer;
    !bvalid_o ##1 bvalid_o;
  endsequence
  // ------------------------------
  // properties
  // ------------------------------
  a_write_answer: assert property (s_wr_taken |=> s_wr_answer)
    else $error("write answer not two cycles after take");
  a_bresp_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write answer dropped early");
  a_read_answer: assert property (arvalid_i && arready_o |=> rvalid_o)
    else $error("read answer late");
  a_rdata_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data changed while waiting");
  a_read_upper_zero: assert property (rvalid_o |-> !arready_o && rdata_o[31:8] == 24'h000000)
    else $error("read upper bits or ready wrong");
  a_req_needs_gate: assert property (irq_req_o |-> global_irq_gate_o)
    else $error("request without gate");
  a_ack_clears_gate: assert property (irq_req_o && irq_ack_i |=> !global_irq_gate_o && !irq_req_o)
    else $error("gate not cleared by taken vector");
  a_stack_blocks_req: assert property (stack_full_i |=> !irq_req_o)
    else $error("request with full stack");
  a_reset_clears: assert property ($rose(rst_b_i) |-> !irq_req_o && !global_irq_gate_o && !irq_o
    && vec_sel_o == 4'h0)
    else $error("outputs not clear after reset");
endmodule : mif_irq_props
bind mif_irq_bank mif_irq_props chk_u (.clk_i, .rst_b_i, .awvalid_i, .awready_o, .wvalid_i, .wready_o,
  .bresp_o, .bvalid_o, .bready_i, .arvalid_i, .arready_o, .rdata_o, .rvalid_o, .rready_i, .stack_full_i,
  .irq_ack_i, .irq_req_o, .vec_sel_o, .global_irq_gate_o, .irq_o);

//--- test/mif_core_model.sv
`timescale 1ns/100ps
module mif_core_model (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic irq_req_i,
  input wire logic [3:0] vec_i,
  input wire logic [3:0] lat_i,
  output logic irq_ack_o,
  output logic [3:0] taken_vec_o,
  output logic [7:0] taken_n_o
);
  logic [3:0] wait_cnt;
  // acks only while a request stands; lat_i models a busy core
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_ack_o <= 1'h0;
      taken_vec_o <= 4'h0;
      taken_n_o <= 8'h00;
      wait_cnt <= 4'h0;
    end else begin
      irq_ack_o <= 1'h0;
      if (irq_req_i && irq_ack_o) begin
        taken_vec_o <= vec_i;
        taken_n_o <= taken_n_o + 8'h01;
        wait_cnt <= 4'h0;
      end else if (irq_req_i) begin
        if (wait_cnt >= lat_i) irq_ack_o <= 1'h1;
        else wait_cnt <= wait_cnt + 4'h1;
      end else wait_cnt <= 4'h0;
    end
  end
endmodule : mif_core_model

//--- test/tb.sv
`timescale 1ns/100ps
`include "mif_cfg.svh"
module tb
  import mif_pkg::*;
;
  typedef struct packed {
    logic [5:0] a;
    logic [7:0] d;
    logic [3:0] s;
    logic [7:0] e;
    logic [1:0] r;
  } mif_row_s;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0, stack_full = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0, lat = 4'h0;
  logic [1:0] ext_pin = 2'h0;
  mif_src_s src = '0;
  wire logic awready, wready, bvalid, arready, rvalid, irq_ack, irq_req, gate, irq;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [31:0] rdata_sv;
  wire logic [3:0] vec, tvec;
  wire logic [7:0] tn;
  int err_total = 0;
  int n_checks = 0;
  mif_row_s rows [0:15] = '{
    '{6'h00, 8'hFF, 4'hF, 8'h0F, 2'h0}, '{6'h00, 8'h00, 4'hF, 8'h00, 2'h0},
    '{6'h10, 8'hFF, 4'hF, 8'h33, 2'h0}, '{6'h14, 8'hFF, 4'hF, 8'hFF, 2'h0},
    '{6'h18, 8'hFF, 4'hF, 8'h33, 2'h0}, '{6'h10, 8'h00, 4'hF, 8'h00, 2'h0},
    '{6'h14, 8'h00, 4'hF, 8'h00, 2'h0}, '{6'h18, 8'h00, 4'hF, 8'h00, 2'h0},
    '{6'h04, 8'hFE, 4'hF, 8'h7E, 2'h0}, '{6'h04, 8'h00, 4'hF, 8'h00, 2'h0},
    '{6'h08, 8'hFF, 4'hF, 8'hFF, 2'h0}, '{6'h08, 8'h00, 4'hF, 8'h00, 2'h0},
    '{6'h0C, 8'hFF, 4'hF, 8'hFF, 2'h0}, '{6'h0C, 8'h00, 4'hF, 8'h00, 2'h0},
    '{6'h08, 8'hFF, 4'h0, 8'h00, 2'h0}, '{6'h24, 8'hFF, 4'hF, 8'h00, 2'h2}};
  always #2.5 clk = ~clk;
  mif_irq_bank #(.SMALL_VARIANT(1'b0)) dut_u (.clk_i(clk), .rst_b_i(rst_b), .awaddr_i(awaddr),
    .awvalid_i(awvalid), .awready_o(awready), .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
    .wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid), .bready_i(bready), .araddr_i(araddr),
    .arvalid_i(arvalid), .arready_o(arready), .rdata_o(rdata), .rresp_o(rresp), .rvalid_o(rvalid),
    .rready_i(rready), .ext_pin_i(ext_pin), .src_i(src), .stack_full_i(stack_full), .irq_ack_i(irq_ack),
    .irq_req_o(irq_req), .vec_sel_o(vec), .global_irq_gate_o(gate), .irq_o(irq));
  mif_core_model core_u (.clk_i(clk), .rst_b_i(rst_b), .irq_req_i(irq_req), .vec_i(vec), .lat_i(lat),
    .irq_ack_o(irq_ack), .taken_vec_o(tvec), .taken_n_o(tn));
  // small variant shares the bus; only its read data are compared
  mif_irq_bank #(.SMALL_VARIANT(1'b1)) dut_small_u (.clk_i(clk), .rst_b_i(rst_b), .awaddr_i(awaddr),
    .awvalid_i(awvalid), .awready_o(), .wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid), .wready_o(),
    .bresp_o(), .bvalid_o(), .bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid), .arready_o(),
    .rdata_o(rdata_sv), .rresp_o(), .rvalid_o(), .rready_i(rready), .ext_pin_i(ext_pin), .src_i(src),
    .stack_full_i(stack_full), .irq_ack_i(irq_ack), .irq_req_o(), .vec_sel_o(), .global_irq_gate_o(), .irq_o());
  // ------------------------------
  // helpers
  // ------------------------------
  task automatic wrap_up();
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [5:0] a, input logic [7:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ah, wh, ad, wd, bh;
    ad = 1'h0;
    wd = 1'h0;
    bh = 1'h0;
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    while (!(ad && wd)) begin
      @(negedge clk);
      ah = awready;
      wh = wready;
      @(posedge clk);
      if (ah && !ad) awvalid <= 1'h0;
      if (wh && !wd) wvalid <= 1'h0;
      ad = ad | ah;
      wd = wd | wh;
    end
    // late bready so the answer has to stand
    repeat (3) @(posedge clk);
    bready <= 1'h1;
    while (!bh) begin
      @(negedge clk);
      bh = bvalid;
      r = bresp;
      @(posedge clk);
    end
    bready <= 1'h0;
  endtask : axi_wr
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    ah = 1'h0;
    rh = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    while (!ah) begin
      @(negedge clk);
      ah = arready;
      @(posedge clk);
    end
    arvalid <= 1'h0;
    @(posedge clk);
    rready <= 1'h1;
    while (!rh) begin
      @(negedge clk);
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
    end
    rready <= 1'h0;
  endtask : axi_rd
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, 4'hF, r);
  endtask : wr
  task automatic rchk(input logic [5:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, {24'h0, e});
  endtask : rchk
  // sel 0 irq, 1 request, 2 taken vector, 3 taken count; sampled mid-cycle
  task automatic mid_chk(input logic [1:0] sel, input logic [31:0] e);
    @(negedge clk);
    case (sel)
      2'h0: chk({31'h0, irq}, e);
      2'h1: chk({31'h0, irq_req}, e);
      2'h2: chk({28'h0, tvec}, e);
      default: chk({24'h0, tn}, e);
    endcase
    @(posedge clk);
  endtask : mid_chk
  task automatic wait_ack(input logic [7:0] n);
    repeat (100) begin
      @(negedge clk);
      if (tn === n) break;
    end
    @(posedge clk);
    chk({24'h0, tn}, {24'h0, n});
  endtask : wait_ack
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0] r;
    logic [7:0] m;
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      axi_wr(rows[i].a, rows[i].d, rows[i].s, r);
      chk({30'h0, r}, {30'h0, rows[i].r});
      axi_rd(rows[i].a, d, r);
      chk(d, {24'h0, rows[i].e});
      m = (rows[i].a == 6'h04) ? 8'hDB : 8'hFF;
      if (rows[i].a == 6'h0C || rows[i].a == 6'h14) m = 8'h33;
      chk(rdata_sv, {24'h0, rows[i].e & m});
      chk({30'h0, r}, {30'h0, rows[i].r});
    end
    for (int c = 0; c < 4; c++) begin
      wr(6'h00, {4'h0, ~c[1:0], c[1:0]});
      ext_pin <= 2'h3;
      repeat (10) @(posedge clk);
      rchk(6'h04, {3'h0, c[0], 4'h0});
      rchk(6'h0C, {2'h0, ~c[0], 5'h0});
      wr(6'h04, 8'h00);
      wr(6'h0C, 8'h00);
      ext_pin <= 2'h0;
      repeat (10) @(posedge clk);
      rchk(6'h04, {3'h0, c[1], 4'h0});
      rchk(6'h0C, {2'h0, ~c[1], 5'h0});
      wr(6'h04, 8'h00);
      wr(6'h0C, 8'h00);
    end
    wr(6'h10, 8'h02);
    src.t0_compare <= 1'h1;
    src.t1_period <= 1'h1;
    src.eeprom <= 1'h1;
    @(posedge clk);
    src <= '0;
    rchk(6'h10, 8'h22);
    rchk(6'h14, 8'h10);
    rchk(6'h18, 8'h20);
    rchk(6'h04, 8'h40);
    wr(6'h10, 8'h00);
    wr(6'h04, 8'h00);
    src.converter <= 1'h1;
    @(posedge clk);
    src.converter <= 1'h0;
    mid_chk(2'h1, 32'h0);
    rchk(6'h08, 8'h40);
    lat <= 4'h3;
    wr(6'h08, 8'h44);
    wr(6'h04, 8'h01);
    wait_ack(8'h01);
    mid_chk(2'h2, 32'h5);
    rchk(6'h04, 8'h00);
    rchk(6'h08, 8'h44);
    stack_full <= 1'h1;
    lat <= 4'h0;
    wr(6'h0C, 8'h22);
    wr(6'h08, 8'h88);
    wr(6'h04, 8'h01);
    mid_chk(2'h1, 32'h0);
    mid_chk(2'h3, 32'h1);
    stack_full <= 1'h0;
    wait_ack(8'h02);
    mid_chk(2'h2, 32'h6);
    wr(6'h08, 8'h00);
    wr(6'h04, 8'h01);
    wait_ack(8'h03);
    mid_chk(2'h2, 32'h8);
    rchk(6'h0C, 8'h02);
    rchk(6'h04, 8'h00);
    rchk(6'h1C, 8'h03);
    mid_chk(2'h0, 32'h0);
    wr(6'h20, 8'h01);
    mid_chk(2'h0, 32'h1);
    wr(6'h1C, 8'h01);
    mid_chk(2'h0, 32'h0);
    rchk(6'h1C, 8'h02);
    wr(6'h20, 8'h03);
    mid_chk(2'h0, 32'h1);
    wr(6'h1C, 8'h02);
    mid_chk(2'h0, 32'h0);
    wr(6'h00, 8'h0F);
    wr(6'h08, 8'hFF);
    rst_b <= 1'h0;
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 9; i++) rchk(6'(4 * i), 8'h00);
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule : tb
